// File: hw/dsm_fifo.sv
// Dual-clock elastic store with gray pointers and a registered read stage
module dsm_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 4, parameter int FW = 4) (
  input wire logic wclk,
  input wire logic wrst_n,
  input wire logic w_valid,
  output logic w_ready,
  input wire logic [WIDTH-1:0] w_data,
  input wire logic rclk,
  input wire logic rrst_n,
  dsm_rd_if.store rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin_ff, wgray_ff, rbin_ff, rgray_ff;
  logic [AW:0] rgray_w, wgray_r;
  logic [WIDTH-1:0] rdata_ff;
  logic ov_ff;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [AW:0] to_bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = g;
    for (int i = AW - 1; i >= 0; i--)
      b[i] = b[i + 1] ^ g[i];
    return b;
  endfunction

  // ------------------------------------------------------------
  // Write side
  // ------------------------------------------------------------
  wire [AW:0] rbin_w = to_bin(rgray_w);
  wire [AW:0] wbin_nxt = wbin_ff + 1'b1;
  wire push = w_valid && w_ready;
  assign w_ready = (wbin_ff - rbin_w) != FULL_CNT;

  always_ff @(posedge wclk)
  begin
    if (!wrst_n)
    begin
      wbin_ff <= '0;
      wgray_ff <= '0;
    end
    else if (push)
    begin
      wbin_ff <= wbin_nxt;
      wgray_ff <= to_gray(wbin_nxt);
    end
  end

  always_ff @(posedge wclk)
  begin
    if (push)
      mem[wbin_ff[AW-1:0]] <= w_data;
  end

  // ------------------------------------------------------------
  // Read side
  // ------------------------------------------------------------
  wire [AW:0] wbin_r = to_bin(wgray_r);
  wire [AW:0] rbin_nxt = rbin_ff + 1'b1;
  wire empty = wbin_r == rbin_ff;
  wire load = !empty && (!ov_ff || rd.r_ready);

  always_ff @(posedge rclk)
  begin
    if (!rrst_n)
    begin
      rbin_ff <= '0;
      rgray_ff <= '0;
      ov_ff <= 1'b0;
    end
    else
    begin
      if (load)
      begin
        rbin_ff <= rbin_nxt;
        rgray_ff <= to_gray(rbin_nxt);
      end
      ov_ff <= load || (ov_ff && !rd.r_ready);
    end
  end

  always_ff @(posedge rclk)
  begin
    if (load)
      rdata_ff <= mem[rbin_ff[AW-1:0]];
  end

  assign rd.r_valid = ov_ff;
  assign rd.r_data = rdata_ff;
  assign rd.r_fill = FW'(wbin_r - rbin_ff) + FW'(ov_ff);

  // Pointers cross as gray code so one bit moves per step
  dsm_sync #(.WIDTH(AW + 1)) u_wsync (
    .clock(rclk),
    .rst_n(rrst_n),
    .d(wgray_ff),
    .q(wgray_r)
  );

  dsm_sync #(.WIDTH(AW + 1)) u_rsync (
    .clock(wclk),
    .rst_n(wrst_n),
    .d(rgray_ff),
    .q(rgray_w)
  );
endmodule

// File: hw/dsm_mapper.sv
// DS3 into STS-1 SPE asynchronous mapper with matching demap path
module dsm_mapper
  import dsm_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int NOM_FILL = NOM_FILL_BITS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ds3_clk,
  input wire logic ds3_in_bit,
  input wire logic ds3_in_valid,
  output logic ds3_in_ready,
  input wire logic oh_ch_en,
  input wire logic [1:0] oh_tx_bits,
  output logic spe_bit,
  output logic spe_valid,
  input wire logic spe_ready,
  output logic spe_sof,
  output logic spe_poh,
  output logic tx_row_stuff,
  output logic tx_underrun,
  input wire logic rx_bit,
  input wire logic rx_valid,
  input wire logic rx_sof,
  output logic ds3_rx_bit,
  output logic ds3_rx_valid,
  output logic [1:0] oh_rx_bits,
  output logic oh_rx_valid
);
  localparam int FW = $clog2(DEPTH) + 2;
  localparam logic [3:0] BCNT_ONE = 4'h1;

  // ------------------------------------------------------------
  // Link-domain reset and DS3 byte assembly
  // ------------------------------------------------------------
  logic link_rst_n;
  logic [BYTE_BITS-1:0] wsr_ff, wbyte_ff;
  logic [2:0] wcnt_ff;
  logic wfull_ff;
  logic w_ready;

  dsm_sync #(.WIDTH(1)) u_rst_sync (
    .clock(ds3_clk),
    .rst_n(1'b1),
    .d(rst_n),
    .q(link_rst_n)
  );

  // Stalls the source only while a finished byte cannot enter the store
  assign ds3_in_ready = !wfull_ff || w_ready;
  wire w_accept = ds3_in_valid && ds3_in_ready;
  wire w_done = w_accept && (wcnt_ff == BIT_LAST);
  wire [BYTE_BITS-1:0] wsr_nxt = {wsr_ff[BYTE_BITS-2:0], ds3_in_bit};

  always_ff @(posedge ds3_clk)
  begin
    if (!link_rst_n)
    begin
      wsr_ff <= '0;
      wcnt_ff <= '0;
      wfull_ff <= 1'b0;
      wbyte_ff <= '0;
    end
    else
    begin
      if (w_accept)
      begin
        wsr_ff <= wsr_nxt;
        wcnt_ff <= wcnt_ff + 1'b1;
      end
      if (w_done)
        wbyte_ff <= wsr_nxt;
      wfull_ff <= w_done || (wfull_ff && !w_ready);
    end
  end

  // ------------------------------------------------------------
  // Elastic store
  // ------------------------------------------------------------
  dsm_rd_if #(.WIDTH(BYTE_BITS), .FW(FW)) rd_if ();

  dsm_fifo #(.WIDTH(BYTE_BITS), .DEPTH(DEPTH), .FW(FW)) u_store (
    .wclk(ds3_clk),
    .wrst_n(link_rst_n),
    .w_valid(wfull_ff),
    .w_ready(w_ready),
    .w_data(wbyte_ff),
    .rclk(clock),
    .rrst_n(rst_n),
    .rd(rd_if.store)
  );

  // ------------------------------------------------------------
  // Transmit position and bit selection
  // ------------------------------------------------------------
  logic [6:0] col_ff;
  logic [2:0] bit_ff;
  logic [3:0] row_ff;
  logic stuff_ff;
  logic [1:0] ohc_ff;
  logic [BYTE_BITS-1:0] sr_ff;
  logic [3:0] bcnt_ff;
  logic spe_bit_ff, spe_valid_ff, spe_sof_ff, spe_poh_ff, underrun_ff;

  wire gen = !spe_valid_ff || spe_ready;
  wire row_start = (col_ff == COL_POH) && (bit_ff == '0);
  wire last_bit = (col_ff == COL_LAST) && (bit_ff == BIT_LAST);
  dsm_bit_e kind;
  assign kind = dsm_bit_kind(col_ff, bit_ff);

  // Fill counted in bits: bytes still stored plus bits left in the shifter
  wire [FW+3:0] fill_bits = {rd_if.r_fill, 3'b000} + {{FW{1'b0}}, bcnt_ff};
  wire [FW+3:0] nom_bits = (FW + 4)'(NOM_FILL);
  wire fill_high = fill_bits > nom_bits;
  wire fill_nom = fill_bits == nom_bits;
  wire row_data = fill_high || (fill_nom && NOM_DATA_ROWS[row_ff]);
  wire nxt_stuff = row_start ? !row_data : stuff_ff;

  wire need_bit = gen && ((kind == BK_DAT) || ((kind == BK_SOP) && !stuff_ff));
  wire have_bit = bcnt_ff != '0;
  wire take = need_bit && have_bit;
  wire data_bit = have_bit ? sr_ff[BYTE_BITS-1] : JUNK_VAL;
  wire ohc_bit = (bit_ff == C2_OHC_FIRST) ? ohc_ff[1] : ohc_ff[0];
  // Refill as the last bit leaves, so back-to-back data bits see no gap
  wire last_take = take && (bcnt_ff == BCNT_ONE);
  assign rd_if.r_ready = !have_bit || last_take;
  wire fetch = rd_if.r_valid && rd_if.r_ready;

  logic nxt_bit;
  always_comb
  begin
    nxt_bit = FIX_VAL;
    case (kind)
      BK_POH: nxt_bit = POH_VAL;
      BK_FIX: nxt_bit = FIX_VAL;
      BK_DAT: nxt_bit = data_bit;
      BK_CTL: nxt_bit = stuff_ff;
      BK_SOP: nxt_bit = stuff_ff ? JUNK_VAL : data_bit;
      BK_OHC: nxt_bit = oh_ch_en ? ohc_bit : FIX_VAL;
      default: nxt_bit = FIX_VAL;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      col_ff <= '0;
      bit_ff <= '0;
      row_ff <= '0;
    end
    else if (gen)
    begin
      bit_ff <= bit_ff + 1'b1;
      if (bit_ff == BIT_LAST)
        col_ff <= (col_ff == COL_LAST) ? COL_POH : col_ff + 1'b1;
      if (last_bit)
        row_ff <= (row_ff == ROW_LAST) ? '0 : row_ff + 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      stuff_ff <= 1'b1;
      ohc_ff <= '0;
    end
    else if (gen && row_start)
    begin
      stuff_ff <= nxt_stuff;
      ohc_ff <= oh_tx_bits;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sr_ff <= '0;
      bcnt_ff <= '0;
    end
    else if (fetch)
    begin
      sr_ff <= rd_if.r_data;
      bcnt_ff <= BYTE_FULL;
    end
    else if (take)
    begin
      sr_ff <= {sr_ff[BYTE_BITS-2:0], 1'b0};
      bcnt_ff <= bcnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      spe_bit_ff <= 1'b0;
      spe_valid_ff <= 1'b0;
      spe_sof_ff <= 1'b0;
      spe_poh_ff <= 1'b0;
      underrun_ff <= 1'b0;
    end
    else
    begin
      underrun_ff <= need_bit && !have_bit;
      if (gen)
      begin
        spe_bit_ff <= nxt_bit;
        spe_valid_ff <= 1'b1;
        spe_sof_ff <= row_start && (row_ff == '0);
        spe_poh_ff <= kind == BK_POH;
      end
    end
  end

  assign spe_bit = spe_bit_ff;
  assign spe_valid = spe_valid_ff;
  assign spe_sof = spe_sof_ff;
  assign spe_poh = spe_poh_ff;
  assign tx_row_stuff = stuff_ff;
  assign tx_underrun = underrun_ff;

  // ------------------------------------------------------------
  // Receive demap
  // ------------------------------------------------------------
  logic [6:0] rcol_ff;
  logic [2:0] rbit_ff;
  logic rlock_ff;
  logic [2:0] ones_ff;
  logic [1:0] ohr_ff;
  logic ds3_rx_bit_ff, ds3_rx_valid_ff, oh_rx_valid_ff;

  wire [6:0] ecol = rx_sof ? COL_POH : rcol_ff;
  wire [2:0] ebit = rx_sof ? 3'h0 : rbit_ff;
  wire r_act = rx_valid && (rlock_ff || rx_sof);
  dsm_bit_e rkind;
  assign rkind = dsm_bit_kind(ecol, ebit);
  wire r_row_start = (ecol == COL_POH) && (ebit == '0);
  // A single corrupted control bit still leaves the majority right
  wire r_stuff = ones_ff >= CTL_MAJORITY;
  wire r_data = (rkind == BK_DAT) || ((rkind == BK_SOP) && !r_stuff);
  wire r_ohc_last = (rkind == BK_OHC) && (ebit == BIT_LAST);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rcol_ff <= '0;
      rbit_ff <= '0;
      rlock_ff <= 1'b0;
      ones_ff <= '0;
      ohr_ff <= '0;
    end
    else if (r_act)
    begin
      rlock_ff <= 1'b1;
      rbit_ff <= ebit + 1'b1;
      if (ebit == BIT_LAST)
        rcol_ff <= (ecol == COL_LAST) ? COL_POH : ecol + 1'b1;
      else
        rcol_ff <= ecol;
      if (r_row_start)
        ones_ff <= '0;
      else if (rkind == BK_CTL)
        ones_ff <= ones_ff + {2'b00, rx_bit};
      if (rkind == BK_OHC)
        ohr_ff <= {ohr_ff[0], rx_bit};
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ds3_rx_bit_ff <= 1'b0;
      ds3_rx_valid_ff <= 1'b0;
      oh_rx_valid_ff <= 1'b0;
    end
    else
    begin
      ds3_rx_valid_ff <= r_act && r_data;
      oh_rx_valid_ff <= r_act && r_ohc_last;
      if (r_act && r_data)
        ds3_rx_bit_ff <= rx_bit;
    end
  end

  assign ds3_rx_bit = ds3_rx_bit_ff;
  assign ds3_rx_valid = ds3_rx_valid_ff;
  assign oh_rx_bits = ohr_ff;
  assign oh_rx_valid = oh_rx_valid_ff;
endmodule

// File: hw/dsm_pkg.sv
// Shared constants, types and the SPE bit-layout decoder for the DS3 mapper
package dsm_pkg;

  // ------------------------------------------------------------
  // Envelope geometry
  // ------------------------------------------------------------
  localparam int SPE_COLS = 87;
  localparam int SPE_ROWS = 9;
  localparam int BYTE_BITS = 8;
  localparam logic [6:0] COL_LAST = 7'(SPE_COLS - 1);
  localparam logic [3:0] ROW_LAST = 4'(SPE_ROWS - 1);
  localparam logic [2:0] BIT_LAST = 3'(BYTE_BITS - 1);
  localparam logic [3:0] BYTE_FULL = 4'(BYTE_BITS);

  // ------------------------------------------------------------
  // Byte columns of one row
  // ------------------------------------------------------------
  localparam logic [6:0] COL_POH = 7'h00;
  localparam logic [6:0] COL_R0 = 7'h01;
  localparam logic [6:0] COL_R1 = 7'h02;
  localparam logic [6:0] COL_C1 = 7'h03;
  localparam logic [6:0] COL_R2 = 7'h1E;
  localparam logic [6:0] COL_R3 = 7'h1F;
  localparam logic [6:0] COL_C2 = 7'h20;
  localparam logic [6:0] COL_R4 = 7'h3A;
  localparam logic [6:0] COL_R5 = 7'h3B;
  localparam logic [6:0] COL_C3 = 7'h3C;

  // ------------------------------------------------------------
  // Bit positions inside the C bytes, bit 0 sent first
  // ------------------------------------------------------------
  localparam logic [2:0] C1_CTL_BIT = 3'h2;
  localparam logic [2:0] CX_CTL_LAST = 3'h1;
  localparam logic [2:0] C2_OHC_FIRST = 3'h6;
  localparam logic [2:0] C3_SOP_BIT = 3'h7;

  // ------------------------------------------------------------
  // Values and decisions
  // ------------------------------------------------------------
  localparam logic FIX_VAL = 1'b0;
  localparam logic JUNK_VAL = 1'b0;
  localparam logic POH_VAL = 1'b0;
  localparam logic [8:0] NOM_DATA_ROWS = 9'h049;
  localparam logic [2:0] CTL_MAJORITY = 3'h3;
  localparam int NOM_FILL_BITS = 16;

  typedef enum logic [2:0] {
    BK_POH = 3'b000,
    BK_FIX = 3'b001,
    BK_DAT = 3'b010,
    BK_CTL = 3'b011,
    BK_SOP = 3'b100,
    BK_OHC = 3'b101
  } dsm_bit_e;

  function automatic dsm_bit_e dsm_bit_kind(input logic [6:0] col, input logic [2:0] bitn);
    dsm_bit_e k;
    k = BK_DAT;
    if (col == COL_POH)
      k = BK_POH;
    else if (col == COL_R0 || col == COL_R1 || col == COL_R2 || col == COL_R3 ||
             col == COL_R4 || col == COL_R5)
      k = BK_FIX;
    else if (col == COL_C1)
      k = (bitn < C1_CTL_BIT) ? BK_FIX : ((bitn == C1_CTL_BIT) ? BK_CTL : BK_DAT);
    else if (col == COL_C2)
      k = (bitn <= CX_CTL_LAST) ? BK_CTL : ((bitn >= C2_OHC_FIRST) ? BK_OHC : BK_FIX);
    else if (col == COL_C3)
      k = (bitn <= CX_CTL_LAST) ? BK_CTL : ((bitn == C3_SOP_BIT) ? BK_SOP : BK_FIX);
    return k;
  endfunction

endpackage

// File: hw/dsm_rd_if.sv
// Read-side carrier between the elastic store and the mapper core
interface dsm_rd_if #(parameter int WIDTH = 8, parameter int FW = 4);
  logic r_valid;
  logic r_ready;
  logic [WIDTH-1:0] r_data;
  logic [FW-1:0] r_fill;
  modport store (output r_valid, output r_data, output r_fill, input r_ready);
  modport user (input r_valid, input r_data, input r_fill, output r_ready);
endinterface

// File: hw/dsm_sync.sv
// Two-flop synchroniser for levels and gray-coded words
module dsm_sync #(parameter int WIDTH = 1) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// File: test/dsm_ds3_src.sv
// DS3 source model on the link clock
module dsm_ds3_src (
  input wire logic ds3_clk,
  input wire logic en,
  input wire logic ds3_in_ready,
  output logic ds3_in_bit,
  output logic ds3_in_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  // Bit and valid held until the link edge that takes them
  always @(posedge ds3_clk)
  begin
    if (!en)
    begin
      cnt_ff <= 8'h00;
      ds3_in_valid <= 1'h0;
    end
    else if (!ds3_in_valid || ds3_in_ready)
    begin
      cnt_ff <= cnt_ff + 8'h01;
      ds3_in_valid <= 1'h1;
    end
  end
  assign ds3_in_bit = cnt_ff[3];
endmodule

// File: test/dsm_mapper_asserts.sv
// Port-level checks of the DS3 mapper
module dsm_mapper_asserts
  import dsm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic oh_ch_en,
  input wire logic [1:0] oh_tx_bits,
  input wire logic spe_bit,
  input wire logic spe_valid,
  input wire logic spe_ready,
  input wire logic spe_sof,
  input wire logic spe_poh,
  input wire logic tx_row_stuff,
  input wire logic rx_valid,
  input wire logic ds3_rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Position in envelope
  // --------
  logic [9:0] pos_ff;
  logic [3:0] row_ff;
  logic [2:0] oh_ff;
  wire xfer = spe_valid & spe_ready;
  wire [6:0] col = pos_ff[9:3];
  wire [2:0] bn = pos_ff[2:0];
  wire row_end = pos_ff == 10'h2B7;
  wire [9:0] nxt_pos = row_end ? 10'h000 : pos_ff + 10'h001;
  wire [3:0] nxt_row = (row_ff == ROW_LAST) ? 4'h0 : row_ff + 4'h1;
  wire in_c23 = col == COL_C2 || col == COL_C3;
  wire is_ctl = (col == COL_C1 && bn == C1_CTL_BIT) || (in_c23 && bn <= CX_CTL_LAST);
  wire is_fix = col inside {COL_R0, COL_R1, COL_R2, COL_R3, COL_R4, COL_R5}
    || (col == COL_C1 && bn < C1_CTL_BIT) || (in_c23 && bn > CX_CTL_LAST && bn < 3'h6)
    || (col == COL_C3 && bn == 3'h6);
  wire is_sop = col == COL_C3 && bn == C3_SOP_BIT;
  wire is_ohc = col == COL_C2 && bn >= C2_OHC_FIRST;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pos_ff <= 10'h000;
      row_ff <= 4'h0;
    end
    else if (xfer)
    begin
      pos_ff <= nxt_pos;
      row_ff <= row_end ? nxt_row : row_ff;
    end
  end

  // Taken on the row's first bit; stimulus only moves mid-row
  always_ff @(posedge clock)
  begin
    if (spe_valid && pos_ff == 10'h000)
      oh_ff <= {oh_ch_en, oh_tx_bits};
  end

  // --------
  // Properties
  // --------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sof_place_a:
  assert property (spe_valid |-> spe_sof == (pos_ff == 10'h000 && row_ff == 4'h0))
    else $error("sof flag away from envelope start");
  poh_span_a:
  assert property (spe_valid |-> spe_poh == (col == COL_POH))
    else $error("poh flag off the first column");
  poh_empty_a:
  assert property (spe_poh |-> spe_bit == POH_VAL)
    else $error("payload in overhead column");
  fix_fill_a:
  assert property (spe_valid && is_fix |-> spe_bit == FIX_VAL)
    else $error("fixed stuff bit value wrong");
  ctl_flag_a:
  assert property (spe_valid && is_ctl |-> spe_bit == tx_row_stuff)
    else $error("control bit disagrees with stuff flag");
  junk_sop_a:
  assert property (spe_valid && is_sop && tx_row_stuff |-> spe_bit == JUNK_VAL)
    else $error("stuffed opportunity not junk");
  ohc_copy_a:
  assert property (spe_valid && is_ohc |-> spe_bit == (oh_ff[2] & oh_ff[~bn[0]]))
    else $error("overhead channel bit wrong");
  row_steady_a:
  assert property (xfer && pos_ff > 10'h018 && pos_ff < 10'h1E2 |=> $stable(tx_row_stuff))
    else $error("stuff decision moved inside a row");
  bit_hold_a:
  assert property (spe_valid && !spe_ready |=> spe_valid && $stable(spe_bit) && $stable(spe_sof))
    else $error("offered bit changed before transfer");
  rx_cause_a:
  assert property (ds3_rx_valid |-> $past(rx_valid))
    else $error("demapped bit without an input bit");
endmodule

bind dsm_mapper dsm_mapper_asserts u_dsm_mapper_asserts (
  .clock, .rst_n, .oh_ch_en, .oh_tx_bits, .spe_bit, .spe_valid,
  .spe_ready, .spe_sof, .spe_poh, .tx_row_stuff, .rx_valid, .ds3_rx_valid
);

// File: test/dsm_mapper_tb.sv
// Self-checking bench for the DS3 into SPE mapper
module dsm_mapper_tb
  import dsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic half; logic oh_en; logic [1:0] oh; logic stuff; logic und;
    logic refd;} dsm_case_s;
  // Starved first, then a throttled output that overfills the store
  localparam dsm_case_s CASES [3] = '{'{1'h0, 1'h1, 2'h2, 1'h1, 1'h1, 1'h0},
    '{1'h1, 1'h0, 2'h3, 1'h0, 1'h0, 1'h1}, '{1'h1, 1'h1, 2'h1, 1'h0, 1'h0, 1'h1}};
  logic clock, rst_n, ds3_clk, ds3_in_bit, ds3_in_valid, ds3_in_ready, oh_ch_en, spe_bit;
  logic spe_valid, spe_ready, spe_sof, spe_poh, tx_row_stuff, tx_underrun, rx_bit, rx_valid;
  logic rx_sof, ds3_rx_bit, ds3_rx_valid, oh_rx_valid, half, flip, src_en;
  logic [1:0] oh_tx_bits, oh_rx_bits, ohe;
  logic [9:0] pos;
  logic cap [696];
  logic q [$];
  int ones, und_cnt, ref_cnt, err_count, compares;
  wire xfer = spe_valid & spe_ready;

  dsm_mapper u_dsm_mapper (.clock, .rst_n, .ds3_clk, .ds3_in_bit, .ds3_in_valid, .ds3_in_ready,
    .oh_ch_en, .oh_tx_bits, .spe_bit, .spe_valid, .spe_ready, .spe_sof, .spe_poh, .tx_row_stuff,
    .tx_underrun, .rx_bit, .rx_valid, .rx_sof, .ds3_rx_bit, .ds3_rx_valid, .oh_rx_bits,
    .oh_rx_valid);
  dsm_ds3_src u_dsm_ds3_src (.ds3_clk, .en(src_en), .ds3_in_ready, .ds3_in_bit, .ds3_in_valid);

  initial
  begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    ds3_clk = 1'h0;
    #13;
    forever #40 ds3_clk = ~ds3_clk;
  end

  // --------
  // Tasks
  // --------
  function automatic int kind_of(input logic [9:0] p);
    if (p[9:3] inside {COL_POH, COL_R0, COL_R1, COL_R2, COL_R3, COL_R4, COL_R5})
      return 1;
    if ((p[9:3] == COL_C1 && p[2:0] == 3'h2) || (p[9:3] inside {COL_C2, COL_C3} && p[2:0] < 3'h2))
      return 2;
    if (p[9:3] == COL_C3 && p[2:0] == 3'h7)
      return 3;
    if (p[9:3] inside {COL_C2, COL_C3} || (p[9:3] == COL_C1 && p[2:0] < 3'h2))
      return 1;
    return 0;
  endfunction
  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_at(input logic [9:0] p);
    for (int n = 0; n < 4000 && pos !== p; n++)
      @(negedge clock);
    if (pos !== p)
    begin
      err_count++;
      $display("unexpected position: expected %0d, seen %0d", p, pos);
      finish_test();
    end
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'h0;
    src_en <= 1'h0;
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk1("spe_valid", 1'h0, spe_valid);
    chk1("ds3_in_ready", 1'h1, ds3_in_ready);
    @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    @(negedge clock);
    chk1("spe_sof", 1'h1, spe_sof);
    chk1("spe_poh", 1'h1, spe_poh);
    repeat (8) @(posedge clock);
    src_en <= 1'h1;
    $display("reset test done");
  endtask

  // --------
  // Loopback and reference
  // --------
  always @(posedge clock)
  begin
    spe_ready <= half ? ~spe_ready : 1'h1;
    rx_bit <= spe_bit ^ (flip && pos == 10'h01A);
    rx_valid <= xfer;
    rx_sof <= spe_sof & xfer;
    if (tx_underrun === 1'h1)
      und_cnt++;
    if (ds3_in_ready === 1'h0)
      ref_cnt++;
    if (ds3_rx_valid === 1'h1)
      chk1("ds3_rx_bit", (q.size() > 0) ? q.pop_front() : 1'hx, ds3_rx_bit);
    if (oh_rx_valid === 1'h1)
    begin
      chk1("oh_rx_bits[1]", ohe[1], oh_rx_bits[1]);
      chk1("oh_rx_bits[0]", ohe[0], oh_rx_bits[0]);
    end
    if (!rst_n)
    begin
      pos <= 10'h000;
      ones = 0;
      q.delete();
    end
    else if (xfer)
    begin
      cap[pos] <= spe_bit;
      if (pos inside {10'h106, 10'h107})
        ohe = {ohe[0], spe_bit};
      if (kind_of(pos) == 2)
        ones = ones + int'(spe_bit);
      if (kind_of(pos) == 0 || (kind_of(pos) == 3 && ones < 3))
        q.push_back(spe_bit);
      if (pos == 10'h2B7)
        ones = 0;
      pos <= (pos == 10'h2B7) ? 10'h000 : pos + 10'h001;
    end
  end

  initial
  begin
    rst_n = 1'h0;
    {spe_ready, half, flip, oh_ch_en, oh_tx_bits, rx_bit, rx_valid, rx_sof, src_en} = '0;
    do_reset();
    foreach (CASES[i])
    begin
      wait_at(10'h12C);
      @(posedge clock);
      half <= CASES[i].half;
      oh_ch_en <= CASES[i].oh_en;
      oh_tx_bits <= CASES[i].oh;
      wait_at(10'h000);
      und_cnt = 0;
      ref_cnt = 0;
      wait_at(10'h12C);
      chk1("tx_row_stuff", CASES[i].stuff, tx_row_stuff);
      wait_at(10'h000);
      chk1("c1 control", CASES[i].stuff, cap[10'h01A]);
      chk1("c3 control", CASES[i].stuff, cap[10'h1E1]);
      chk1("ohc first", CASES[i].oh_en & CASES[i].oh[1], cap[10'h106]);
      chk1("ohc second", CASES[i].oh_en & CASES[i].oh[0], cap[10'h107]);
      chk1("underrun", CASES[i].und, und_cnt > 0);
      chk1("refusal", CASES[i].refd, ref_cnt > 0);
      $display("case %0d done", i);
    end
    // One control bit per row corrupted on the way back, in two rows; the vote must hold
    @(posedge clock);
    flip <= 1'h1;
    wait_at(10'h12C);
    wait_at(10'h000);
    wait_at(10'h12C);
    @(posedge clock);
    flip <= 1'h0;
    $display("vote test done");
    do_reset();
    wait_at(10'h12C);
    finish_test();
  end
endmodule
